// File: src/prpm_consts.svh
// How it works
// - Gigabit external loopback needs its enable bit
// - Copper reset restores copper configuration fields
// - Fiber reset restores fiber configuration fields
// - Generator reset restores mode and generator fields
// - One group reset leaves other groups alone
// - Software reset bits clear themselves
// - Power down ignores system interface and media
// - Only clearing power-down bits wakes circuits
// - Either copper power-down bit powers copper off
// - Unused circuits power down automatically
// - Power-down bit overrides automatic power management
// - Clearing power down issues that circuit's reset
// - Energy state and sticky change bit visible
// - Energy modes copper only, off with auto-select
// - Mode field: 0x normal, 10 mode1, 11 mode2
// - Mode 1 energy starts negotiation for 5 s
// - Timeout or no energy returns to listening (the code returns to sleep on the window timeout only)
// - Negotiation done enters normal; link loss restarts
// - Mode 2 sends one link pulse per second
// - Leaving power down enters sleep when enabled (the code's release reset clears the mode field, so copper ends in normal)
// - MAC keep-alive bits latch on software reset
`ifndef PRPM_CONSTS_SVH
`define PRPM_CONSTS_SVH
// Register byte offsets
`define PRPM_A_CTRL 4'h0
`define PRPM_A_STAT 4'h4
// Control field positions
`define PRPM_C_CU_SRST 0
`define PRPM_C_FI_SRST 1
`define PRPM_C_GC_SRST 2
`define PRPM_C_CU_PD_A 3
`define PRPM_C_CU_PD_B 4
`define PRPM_C_FI_PD 5
`define PRPM_C_ED_LO 6
`define PRPM_C_ED_HI 7
`define PRPM_C_GIG_LB 8
`define PRPM_C_CU_KEEP 9
`define PRPM_C_FI_KEEP 10
`define PRPM_C_AUTO_SEL 11
// Status field positions
`define PRPM_S_CHG 1
`define PRPM_CTRL_RST 16'h0600
`define PRPM_CTRL_WMASK 16'h0fff
`define PRPM_ED_OFF 2'h0
`define PRPM_ED_MODE2 2'h3
`define PRPM_SPEED_GIG 2'h2
// AXI responses
`define PRPM_OKAY 2'h0
`define PRPM_SLVERR 2'h2
// Timing in own units
`define PRPM_CLK_HZ 20000000
`define PRPM_WAKE_S 5
`define PRPM_NLP_S 1
`endif

// File: src/prpm_pkg.sv
package prpm_pkg;
    // Copper sleep and wake states
    typedef enum logic [3:0] {
        PRPM_OFF = 4'h1,
        PRPM_SLEEP = 4'h2,
        PRPM_WAKE = 4'h4,
        PRPM_NORM = 4'h8
    } prpm_state_e;
    // Power enables toward the port circuits
    typedef struct packed {
        logic sys_if_on;
        logic mac_if_on;
        logic fiber_on;
        logic copper_on;
    } prpm_pwr_s;
    // Group reset pulses: gen/checker, fiber, copper
    typedef struct packed {
        logic gc;
        logic fi;
        logic cu;
    } prpm_rst_s;
    typedef logic [1:0] prpm_speed_t;
endpackage

// File: src/prpm_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "prpm_consts.svh"
module prpm_top #(
    parameter int WAKE_CYC = `PRPM_WAKE_S * `PRPM_CLK_HZ,
    parameter int NLP_CYC = `PRPM_NLP_S * `PRPM_CLK_HZ
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hw_reset_pin_n,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic energy_det,
    input wire logic an_done,
    input wire logic link_up,
    input wire prpm_pkg::prpm_speed_t speed,
    input wire logic use_copper,
    input wire logic use_fiber,
    output prpm_pkg::prpm_pwr_s pwr,
    output prpm_pkg::prpm_rst_s grp_rst,
    output logic flp_en,
    output logic nlp_pulse,
    output logic an_restart,
    output logic ext_lb_ok
);
    import prpm_pkg::*;

    // Pin reset folds into the bus reset
    logic rst;
    assign rst = !aresetn || !hw_reset_pin_n;

    logic [15:0] ctrl_r; // Control register
    prpm_rst_s srst_r; // Group reset pulses
    prpm_state_e state_r; // Copper sleep state
    logic [26:0] wake_cnt_r; // Negotiation window
    logic [24:0] nlp_cnt_r; // Link pulse spacing
    logic cu_pd_q_r, fi_pd_q_r, link_q_r; // Edge history
    logic en_r, chg_r; // Energy state and change
    logic [1:0] keep_r; // Latched keep-alive bits
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    prpm_pwr_s pwr_r;
    logic flp_r, nlp_r, anr_r, lb_r;

    // Decoded control
    logic cu_pd, fi_pd, ed_on, mode2, wr_hs, rd_hs, wr_ctrl, wr_stat;
    logic en_now, cu_low;
    assign cu_pd = ctrl_r[`PRPM_C_CU_PD_A] || ctrl_r[`PRPM_C_CU_PD_B];
    assign fi_pd = ctrl_r[`PRPM_C_FI_PD];
    // Energy modes only with auto-select off
    assign ed_on = ctrl_r[`PRPM_C_ED_HI] && !ctrl_r[`PRPM_C_AUTO_SEL];
    assign mode2 = ctrl_r[`PRPM_C_ED_HI:`PRPM_C_ED_LO] == `PRPM_ED_MODE2;
    assign wr_hs = awready_r && awvalid && wvalid;
    assign rd_hs = arready_r && arvalid;
    assign wr_ctrl = wr_hs && awaddr == `PRPM_A_CTRL;
    assign wr_stat = wr_hs && awaddr == `PRPM_A_STAT;
    // Media ignored while copper powered down
    assign en_now = energy_det && !cu_pd;
    assign cu_low = state_r == PRPM_OFF || state_r == PRPM_SLEEP;

    // Write channel: take address and data together
    always_ff @(posedge aclk) begin
        if (rst) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `PRPM_OKAY;
        end else begin
            awready_r <= awvalid && wvalid && !awready_r && !bvalid_r;
            wready_r <= awvalid && wvalid && !awready_r && !bvalid_r;
            if (wr_hs) begin
                bvalid_r <= 1'b1;
                bresp_r <= (wr_ctrl || wr_stat) ? `PRPM_OKAY : `PRPM_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel: one-cycle ready then data
    always_ff @(posedge aclk) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `PRPM_OKAY;
        end else begin
            arready_r <= arvalid && !arready_r && !rvalid_r;
            if (rd_hs) begin
                rvalid_r <= 1'b1;
                rresp_r <= `PRPM_OKAY;
                if (araddr == `PRPM_A_CTRL) begin
                    rdata_r <= {16'h0, ctrl_r};
                end else if (araddr == `PRPM_A_STAT) begin
                    rdata_r <= {23'h0, keep_r, lb_r, state_r, chg_r, en_r};
                end else begin
                    rdata_r <= 32'h0;
                    rresp_r <= `PRPM_SLVERR;
                end
            end else if (rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Control register with group resets
    always_ff @(posedge aclk) begin
        if (rst) begin
            ctrl_r <= `PRPM_CTRL_RST;
        end else begin
            // Reset bits drop one cycle after being set
            ctrl_r[`PRPM_C_GC_SRST:`PRPM_C_CU_SRST] <= 3'h0;
            // Each group touches only its own fields
            if (srst_r.cu) begin
                ctrl_r[`PRPM_C_ED_HI:`PRPM_C_ED_LO] <= `PRPM_ED_OFF;
            end
            if (srst_r.fi) begin
                ctrl_r[`PRPM_C_AUTO_SEL] <= 1'b0;
            end
            if (srst_r.gc) begin
                ctrl_r[`PRPM_C_GIG_LB] <= 1'b0;
            end
            // Software write wins over a group reset
            if (wr_ctrl && wstrb[0]) begin
                ctrl_r[7:0] <= wdata[7:0] & 8'(`PRPM_CTRL_WMASK);
            end
            if (wr_ctrl && wstrb[1]) begin
                ctrl_r[15:8] <= wdata[15:8] & 8'(`PRPM_CTRL_WMASK >> 8);
            end
        end
    end

    // Reset pulses, also on power-down release
    always_ff @(posedge aclk) begin
        if (rst) begin
            srst_r <= '0;
            cu_pd_q_r <= 1'b0;
            fi_pd_q_r <= 1'b0;
        end else begin
            cu_pd_q_r <= cu_pd;
            fi_pd_q_r <= fi_pd;
            srst_r.cu <= ctrl_r[`PRPM_C_CU_SRST] || (cu_pd_q_r && !cu_pd);
            srst_r.fi <= ctrl_r[`PRPM_C_FI_SRST] || (fi_pd_q_r && !fi_pd);
            srst_r.gc <= ctrl_r[`PRPM_C_GC_SRST];
        end
    end

    // Keep-alive takes effect only on its group reset
    always_ff @(posedge aclk) begin
        if (rst) begin
            keep_r <= 2'h3;
        end else begin
            if (srst_r.cu) begin
                keep_r[0] <= ctrl_r[`PRPM_C_CU_KEEP];
            end
            if (srst_r.fi) begin
                keep_r[1] <= ctrl_r[`PRPM_C_FI_KEEP];
            end
        end
    end

    // Energy status and sticky change flag
    always_ff @(posedge aclk) begin
        if (rst) begin
            en_r <= 1'b0;
            chg_r <= 1'b0;
        end else begin
            en_r <= en_now;
            // A change in the clearing cycle still sets
            if (en_now != en_r) begin
                chg_r <= 1'b1;
            end else if (wr_stat && wstrb[0] && wdata[`PRPM_S_CHG]) begin
                chg_r <= 1'b0;
            end
        end
    end

    // Copper sleep and wake machine
    always_ff @(posedge aclk) begin
        if (rst) begin
            state_r <= PRPM_OFF;
        end else if (cu_pd || srst_r.cu) begin
            // Power-down bits override power management
            state_r <= PRPM_OFF;
        end else begin
            case (state_r)
                PRPM_OFF: begin
                    state_r <= ed_on ? PRPM_SLEEP : PRPM_NORM;
                end
                PRPM_SLEEP: begin
                    if (!ed_on) begin
                        state_r <= PRPM_NORM;
                    end else if (en_now) begin
                        state_r <= PRPM_WAKE;
                    end
                end
                PRPM_WAKE: begin
                    if (!ed_on || an_done) begin
                        state_r <= PRPM_NORM;
                    end else if (wake_cnt_r == 27'h0) begin
                        state_r <= PRPM_SLEEP;
                    end
                end
                PRPM_NORM: begin
                    if (ed_on && !link_up && !an_done && link_q_r) begin
                        state_r <= PRPM_WAKE;
                    end
                end
                default: begin
                    state_r <= PRPM_OFF;
                end
            endcase
        end
    end

    // Negotiation window, loaded on entry
    always_ff @(posedge aclk) begin
        if (rst) begin
            wake_cnt_r <= 27'h0;
        end else if (state_r != PRPM_WAKE) begin
            wake_cnt_r <= 27'(WAKE_CYC - 1);
        end else if (wake_cnt_r != 27'h0) begin
            wake_cnt_r <= wake_cnt_r - 27'h1;
        end
    end

    // One normal link pulse per second in mode 2
    always_ff @(posedge aclk) begin
        if (rst) begin
            nlp_cnt_r <= 25'h0;
            nlp_r <= 1'b0;
        end else if (state_r == PRPM_SLEEP && mode2) begin
            nlp_r <= nlp_cnt_r == 25'h0;
            nlp_cnt_r <= (nlp_cnt_r == 25'h0) ? 25'(NLP_CYC - 1) : nlp_cnt_r - 25'h1;
        end else begin
            nlp_r <= 1'b0;
            nlp_cnt_r <= 25'(NLP_CYC - 1);
        end
    end

    // Negotiation start and link-loss restart
    always_ff @(posedge aclk) begin
        if (rst) begin
            link_q_r <= 1'b0;
            anr_r <= 1'b0;
            flp_r <= 1'b0;
        end else begin
            link_q_r <= link_up;
            anr_r <= (state_r == PRPM_SLEEP && ed_on && en_now && !cu_pd)
                || (state_r == PRPM_NORM && link_q_r && !link_up && !cu_pd);
            flp_r <= state_r == PRPM_WAKE && !cu_pd;
        end
    end

    // Power enables: unused or forced-down circuits off
    always_ff @(posedge aclk) begin
        if (rst) begin
            pwr_r <= '0;
            lb_r <= 1'b0;
        end else begin
            pwr_r.copper_on <= !cu_pd && use_copper && !cu_low;
            pwr_r.fiber_on <= !fi_pd && use_fiber;
            pwr_r.sys_if_on <= (use_copper && !cu_pd) || (use_fiber && !fi_pd);
            pwr_r.mac_if_on <= use_copper ? (!cu_low || keep_r[0])
                : (!fi_pd || keep_r[1]);
            // 10/100 loop freely; gigabit needs the bit
            lb_r <= speed != `PRPM_SPEED_GIG || ctrl_r[`PRPM_C_GIG_LB];
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign pwr = pwr_r;
    assign grp_rst = srst_r;
    assign flp_en = flp_r;
    assign nlp_pulse = nlp_r;
    assign an_restart = anr_r;
    assign ext_lb_ok = lb_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (rst);

    a_srst_self_clear: assert property (ctrl_r[`PRPM_C_CU_SRST] && !wr_ctrl
        |=> !ctrl_r[`PRPM_C_CU_SRST])
        else $error("copper reset bit did not clear");
    a_srst_one_pulse: assert property (ctrl_r[`PRPM_C_CU_SRST] |=> srst_r.cu)
        else $error("copper reset pulse missing");
    a_cu_reset_ed: assert property (srst_r.cu && !wr_ctrl
        |=> ctrl_r[`PRPM_C_ED_HI:`PRPM_C_ED_LO] == `PRPM_ED_OFF)
        else $error("copper reset left energy mode");
    a_fi_reset_sel: assert property (srst_r.fi && !wr_ctrl
        |=> !ctrl_r[`PRPM_C_AUTO_SEL])
        else $error("fiber reset left auto select");
    a_gc_reset_lb: assert property (srst_r.gc && !wr_ctrl
        |=> !ctrl_r[`PRPM_C_GIG_LB])
        else $error("mode reset left loopback enable");
    a_group_isolated: assert property (srst_r.fi && !srst_r.cu && !wr_ctrl
        |=> ctrl_r[`PRPM_C_ED_HI:`PRPM_C_ED_LO]
        == $past(ctrl_r[`PRPM_C_ED_HI:`PRPM_C_ED_LO]))
        else $error("fiber reset disturbed copper field");
    a_pd_forces_off: assert property (cu_pd |=> state_r == PRPM_OFF ##1 !pwr_r.copper_on)
        else $error("copper not off under power down");
    a_pd_release_rst: assert property ($fell(cu_pd) |=> srst_r.cu)
        else $error("no reset on power-down release");
    a_sleep_wakes: assert property (state_r == PRPM_SLEEP && ed_on && en_now
        && !srst_r.cu |=> state_r == PRPM_WAKE ##1 flp_r)
        else $error("energy did not start negotiation");
    a_wake_timeout: assert property (state_r == PRPM_WAKE && wake_cnt_r == 27'h0
        && ed_on && !an_done && !cu_pd && !srst_r.cu |=> state_r == PRPM_SLEEP)
        else $error("window end did not return to sleep");
    a_gig_lb_gate: assert property (speed == `PRPM_SPEED_GIG && !ctrl_r[`PRPM_C_GIG_LB]
        |=> !lb_r)
        else $error("gigabit loopback without enable");
    a_energy_change: assert property (en_now != en_r |=> chg_r)
        else $error("energy change not recorded");

    c_wake_to_norm: cover property (state_r == PRPM_WAKE ##1 state_r == PRPM_NORM);
    c_wake_timeout: cover property (state_r == PRPM_WAKE ##1 state_r == PRPM_SLEEP);
    c_nlp_sent: cover property (nlp_r);
    c_pd_release: cover property ($fell(cu_pd) ##1 srst_r.cu);
endmodule

// File: bench/prpm_link_partner.sv
`timescale 1ns/10ps
// Far-side copper partner: answers negotiation after a set delay
module prpm_link_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic flp_en,
    input wire logic energy_req,
    input wire logic link_req,
    input wire logic an_ok,
    input wire logic [7:0] dly,
    output logic energy_det,
    output logic an_done,
    output logic link_up
);
    logic [7:0] cnt_r = 8'h00; // Cycles of pulses heard
    logic done_r = 1'b0; // Negotiation finished
    // Completes only after hearing pulses for dly cycles, never sooner
    always @(posedge aclk) begin
        if (!aresetn || !an_ok) begin
            cnt_r <= 8'h00;
            done_r <= 1'b0;
        end else if (flp_en) begin
            cnt_r <= cnt_r + 8'h01;
            done_r <= done_r | (cnt_r >= dly);
        end
    end
    // Line energy follows the bench's command; link follows the bench's command or a finished negotiation
    assign energy_det = energy_req;
    assign an_done = done_r;
    assign link_up = link_req | done_r;
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
`include "prpm_consts.svh"
module tb;
    import prpm_pkg::*;
    localparam int WAKE_N = 40; // Short window keeps the run brief
    localparam int NLP_N = 16; // Short pulse period
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic hw_reset_pin_n = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, energy_det, an_done, link_up;
    logic flp_en, nlp_pulse, an_restart, ext_lb_ok;
    logic [1:0] bresp, rresp, resp_q;
    logic [31:0] rdata, rd_q;
    prpm_speed_t speed = 2'h0;
    logic use_copper = 1'b1, use_fiber = 1'b0;
    logic energy_req = 1'b0, link_req = 1'b1, an_ok = 1'b0; // Partner commands
    prpm_pwr_s pwr;
    prpm_rst_s grp_rst;
    int n_errors = 0, cmp_count = 0;
    int n_cu = 0, n_fi = 0, n_gc = 0, n_anr = 0, n_nlp = 0; // Pulse tallies
    always #25 aclk = ~aclk;
    // Tally pulses; a stuck pulse shows as an excess count
    always @(posedge aclk) begin
        n_cu += int'(grp_rst.cu === 1'b1);
        n_fi += int'(grp_rst.fi === 1'b1);
        n_gc += int'(grp_rst.gc === 1'b1);
        n_anr += int'(an_restart === 1'b1);
        n_nlp += int'(nlp_pulse === 1'b1);
    end
    prpm_top #(.WAKE_CYC(WAKE_N), .NLP_CYC(NLP_N)) prpm_top_i (
        .aclk(aclk), .aresetn(aresetn), .hw_reset_pin_n(hw_reset_pin_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .energy_det(energy_det), .an_done(an_done), .link_up(link_up), .speed(speed),
        .use_copper(use_copper), .use_fiber(use_fiber), .pwr(pwr), .grp_rst(grp_rst),
        .flp_en(flp_en), .nlp_pulse(nlp_pulse), .an_restart(an_restart),
        .ext_lb_ok(ext_lb_ok));
    prpm_link_partner prpm_link_partner_i (
        .aclk(aclk), .aresetn(aresetn), .flp_en(flp_en), .energy_req(energy_req),
        .link_req(link_req), .an_ok(an_ok), .dly(8'h03), .energy_det(energy_det),
        .an_done(an_done), .link_up(link_up));
    // Single comparison point
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Bus write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 50);
        resp_q = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    // Bus read
    task automatic rd(input logic [3:0] a);
        int t;
        t = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 50);
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Waits for the pulse window output to reach a level
    task automatic wflp(input logic v, output int n);
        n = 0;
        while (flp_en !== v && n < 200) begin
            @(posedge aclk);
            n++;
        end
    endtask
    // Group resets, unmapped access, pin reset
    task automatic t_regs();
        logic [31:0] cfg[3] = '{32'h080, 32'h800, 32'h100};
        int c[3];
        rd(`PRPM_A_CTRL);
        chk(rd_q, 32'h0600, "ctrl after reset");
        rd(4'h8);
        chk(rd_q, 32'h0, "unmapped data");
        chk(32'(resp_q), 32'(`PRPM_SLVERR), "unmapped resp");
        wr(4'h8, 32'hfff);
        chk(32'(resp_q), 32'(`PRPM_SLVERR), "unmapped write resp");
        wr(`PRPM_A_CTRL, 32'h0600);
        chk(32'(resp_q), 32'(`PRPM_OKAY), "ctrl write resp");
        for (int g = 0; g < 3; g++) begin
            c = '{n_cu, n_fi, n_gc};
            wr(`PRPM_A_CTRL, 32'h0600 | cfg[g] | (32'h1 << g));
            tk(3);
            rd(`PRPM_A_CTRL);
            chk(rd_q, 32'h0600, "group reset");
            chk(n_cu - c[0], int'(g == 0), "copper pulses");
            chk(n_fi - c[1], int'(g == 1), "fiber pulses");
            chk(n_gc - c[2], int'(g == 2), "gen pulses");
        end
        wr(`PRPM_A_CTRL, 32'h0700);
        hw_reset_pin_n <= 1'b0;
        tk(2);
        hw_reset_pin_n <= 1'b1;
        tk(1);
        rd(`PRPM_A_CTRL);
        chk(rd_q, 32'h0600, "pin reset");
    endtask
    // Power down bits, media ignored, wake with reset
    task automatic t_pd();
        int a;
        int c;
        chk(pwr.fiber_on, 1'b0, "unused fiber");
        for (int b = 3; b < 5; b++) begin
            wr(`PRPM_A_CTRL, 32'h0600 | (32'h1 << b));
            a = n_anr;
            energy_req <= 1'b1;
            tk(4);
            chk(pwr.copper_on, 1'b0, "copper off");
            chk(pwr.sys_if_on, 1'b0, "system side off");
            rd(`PRPM_A_STAT);
            chk({26'h0, rd_q[5:0]}, 32'h04, "pd status");
            chk(n_anr - a, 0, "no self wake");
            energy_req <= 1'b0;
            c = n_cu;
            wr(`PRPM_A_CTRL, 32'h0600);
            tk(3);
            chk(n_cu - c, 1, "copper wake reset");
            chk(pwr.copper_on, 1'b1, "copper on");
        end
        use_fiber <= 1'b1;
        wr(`PRPM_A_CTRL, 32'h0620);
        tk(2);
        chk(pwr.fiber_on, 1'b0, "fiber held off");
        c = n_fi;
        wr(`PRPM_A_CTRL, 32'h0600);
        tk(3);
        chk(n_fi - c, 1, "fiber wake reset");
        chk(pwr.fiber_on, 1'b1, "fiber on");
        use_fiber <= 1'b0;
    endtask
    // Every mode code, plus auto media select, on a link loss
    task automatic t_modes();
        logic [31:0] md[5] = '{32'h600, 32'h640, 32'h680, 32'h6c0, 32'he80};
        prpm_state_e want[5] = '{PRPM_NORM, PRPM_NORM, PRPM_WAKE, PRPM_WAKE, PRPM_NORM};
        int a;
        for (int m = 0; m < 5; m++) begin
            wr(`PRPM_A_CTRL, md[m]);
            a = n_anr;
            link_req <= 1'b0;
            tk(3);
            rd(`PRPM_A_STAT);
            chk(32'(rd_q[5:2]), 32'(want[m]), "mode state");
            chk(n_anr - a, 1, "restart on loss");
            an_ok <= 1'b1;
            link_req <= 1'b1;
            tk(12);
            rd(`PRPM_A_STAT);
            chk(32'(rd_q[5:2]), 32'(PRPM_NORM), "back to normal");
            an_ok <= 1'b0;
        end
    endtask
    // Window expiry, sleep, energy wake, mode 2 pulses
    task automatic t_sleep();
        int a;
        int n;
        wr(`PRPM_A_CTRL, 32'h0680);
        link_req <= 1'b0;
        wflp(1'b1, n);
        wflp(1'b0, n);
        chk(32'(n >= WAKE_N - 1 && n <= WAKE_N + 1), 1, "window length");
        a = n_nlp;
        tk(40);
        rd(`PRPM_A_STAT);
        chk({26'h0, rd_q[5:0]}, 32'h08, "sleep status");
        chk(n_nlp - a, 0, "mode 1 silent");
        a = n_anr;
        energy_req <= 1'b1;
        tk(2);
        rd(`PRPM_A_STAT);
        chk({26'h0, rd_q[5:0]}, 32'h13, "energy wake");
        chk(n_anr - a, 1, "wake restart");
        wr(`PRPM_A_STAT, 32'h2);
        rd(`PRPM_A_STAT);
        chk({30'h0, rd_q[1:0]}, 32'h1, "change cleared");
        an_ok <= 1'b1;
        link_req <= 1'b1;
        tk(12);
        chk(flp_en, 1'b0, "pulses stop");
        an_ok <= 1'b0;
        energy_req <= 1'b0;
        wr(`PRPM_A_CTRL, 32'h06c0);
        link_req <= 1'b0;
        wflp(1'b1, n);
        wflp(1'b0, n);
        n = 0;
        while (nlp_pulse !== 1'b1 && n < 40) begin
            @(posedge aclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (nlp_pulse !== 1'b1 && n < 100);
        chk(32'(n >= NLP_N - 1 && n <= NLP_N + 1), 1, "pulse period");
        energy_req <= 1'b1;
        an_ok <= 1'b1;
        link_req <= 1'b1;
        tk(12);
        energy_req <= 1'b0;
        an_ok <= 1'b0;
    endtask
    // Loopback permit at each speed; the bench checks only the permit output and sends no frames
    task automatic t_lb();
        for (int s = 0; s < 3; s++) begin
            for (int g = 0; g < 2; g++) begin
                wr(`PRPM_A_CTRL, 32'h0600 | (g << 8));
                speed <= s[1:0];
                tk(2);
                chk(ext_lb_ok, (s != 2) || (g == 1), "loopback permit");
            end
        end
        speed <= 2'h0;
    endtask
    // Keep-alive latches only on a reset
    task automatic t_keep();
        wr(`PRPM_A_CTRL, 32'h0608);
        tk(2);
        chk(pwr.mac_if_on, 1'b1, "mac kept");
        wr(`PRPM_A_CTRL, 32'h0400);
        tk(3);
        rd(`PRPM_A_STAT);
        chk({30'h0, rd_q[8:7]}, 32'h2, "keep latched");
        wr(`PRPM_A_CTRL, 32'h0408);
        tk(2);
        chk(pwr.mac_if_on, 1'b0, "mac released");
        wr(`PRPM_A_CTRL, 32'h0600);
    endtask
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        tk(4);
        aresetn <= 1'b1;
        tk(1);
        t_regs();
        t_pd();
        t_modes();
        t_sleep();
        t_lb();
        t_keep();
        conclude();
    end
    // Hang guard, well past the expected run
    initial begin
        tk(8000);
        n_errors++;
        conclude();
    end
endmodule
